// File: cdms_pkg.sv
// package: register map, field layout and encodings of the clock divider block
package cdms_pkg;
    // byte addresses of the word registers
    localparam logic [7:0] CDMS_ADR_DIV = 8'h00;
    localparam logic [7:0] CDMS_ADR_OSTD = 8'h04;
    localparam logic [7:0] CDMS_ADR_MSTPA = 8'h08;
    localparam logic [7:0] CDMS_ADR_PWR = 8'h0C;
    localparam logic [7:0] CDMS_ADR_STAT = 8'h10;
    // divider field low bit positions
    localparam int CDMS_POS_PD = 0;
    localparam int CDMS_POS_PC = 4;
    localparam int CDMS_POS_PB = 8;
    localparam int CDMS_POS_PA = 12;
    localparam int CDMS_POS_BUS = 16;
    localparam int CDMS_POS_CORE = 24;
    localparam int CDMS_POS_FLASH = 28;
    localparam logic [3:0] CDMS_DIV_MAX = 4'h6;
    localparam int CDMS_CNT_W = 6;
    // oscillation-stop enable bit
    localparam int CDMS_POS_OSC_STOP_DETECT_ENABLE = 7;
    // module-stop bits
    localparam int CDMS_POS_CMTW1 = 0;
    localparam int CDMS_POS_CMTW0 = 1;
    localparam int CDMS_POS_TPU0 = 13;
    localparam int CDMS_POS_ADC1 = 16;
    // power control register fields
    localparam int CDMS_POS_BUSPIN = 0;
    localparam int CDMS_POS_SDPIN = 1;
    localparam int CDMS_POS_OPM = 4;
    localparam int CDMS_POS_LPM = 8;
    localparam int CDMS_POS_ENTER = 12;
    // reset values
    localparam logic [31:0] CDMS_RST_DIV = 32'h2222_2222;
    localparam logic [7:0] CDMS_RST_OSTD = 8'h00;
    localparam logic [31:0] CDMS_RST_MSTPA = 32'hFFFF_FFFF;
    localparam logic [1:0] CDMS_RST_OPM = 2'h0;
    localparam logic [1:0] CDMS_RST_LPM = 2'h0;
    // low-power mode codes
    localparam logic [1:0] CDMS_LPM_SLEEP = 2'h0;
    localparam logic [1:0] CDMS_LPM_ALLSTOP = 2'h1;
    localparam logic [1:0] CDMS_LPM_SWSTBY = 2'h2;
    localparam logic [1:0] CDMS_LPM_DEEP = 2'h3;
    // operating power control mode codes; low-speed 1 and 2 draw the same
    localparam logic [1:0] CDMS_OPM_HIGH = 2'h0;
    localparam logic [1:0] CDMS_OPM_LOW1 = 2'h1;
    localparam logic [1:0] CDMS_OPM_LOW2 = 2'h2;
    // run / low-power states
    typedef enum logic [1:0] {
        CDMS_ST_RUN = 2'b01,
        CDMS_ST_LOW = 2'b10
    } cdms_state_t;
    // clock enable bundle, one per derived clock
    typedef struct packed {
        logic flash;
        logic core;
        logic bus;
        logic pa;
        logic pb;
        logic pc;
        logic pd;
    } cdms_clk_en_t;
endpackage

// File: cdms_top.sv
// clock divider, pin clock control and module-stop logic with wishbone slave
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
module cdms_top
    import cdms_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wake_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output cdms_clk_en_t clk_en_o,
    output logic [31:0] mod_run_o,
    output logic bus_pin_o,
    output logic sdram_pin_o,
    output logic osc_stop_detect_enable_o,
    output logic [1:0] opmode_o,
    output logic [1:0] lpm_o,
    output logic low_power_o
);
    logic [31:0] div_q;
    logic osc_stop_detect_enable_q;
    logic [31:0] mstpa_q;
    logic bus_pin_en_q;
    logic sd_pin_en_q;
    logic [1:0] opm_q;
    logic [1:0] lpm_q;
    cdms_state_t st_q;
    logic [CDMS_CNT_W-1:0] cnt_q;
    logic wake_m_q;
    logic wake_s_q;
    logic acc;
    logic wr;
    logic enter;
    logic [31:0] rd_d;
    logic [6:0] raw_en;
    logic [6:0] gate;

    // merge write data into an old word by byte lane
    function automatic logic [31:0] lane_wr(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // divide mask for a code; prohibited codes behave as the slowest ratio
    function automatic logic [CDMS_CNT_W-1:0] div_mask(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CDMS_DIV_MAX) ? CDMS_DIV_MAX : code;
        return CDMS_CNT_W'((7'h01 << c) - 7'h01);
    endfunction

    assign acc = cyc_i && stb_i && !ack_o;
    assign wr = acc && we_i;
    assign enter = wr && (adr_i == CDMS_ADR_PWR) && sel_i[1] && dat_i[CDMS_POS_ENTER];

    // wake pin synchroniser; only the second stage is used
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_m_q <= 1'b0;
            wake_s_q <= 1'b0;
        end else if (ce_i) begin
            wake_m_q <= wake_i;
            wake_s_q <= wake_m_q;
        end
    end

    // wishbone ack: one wait state, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= acc;
        end
    end

    // divider control register, written by byte lane, so the two fields sharing a lane are written together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= CDMS_RST_DIV;
        end else if (ce_i && wr && adr_i == CDMS_ADR_DIV) begin
            div_q <= lane_wr(div_q, dat_i, sel_i);
        end
    end

    // oscillation-stop detection control, only the enable bit is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_stop_detect_enable_q <= CDMS_RST_OSTD[CDMS_POS_OSC_STOP_DETECT_ENABLE];
        end else if (ce_i && wr && adr_i == CDMS_ADR_OSTD && sel_i[0]) begin
            osc_stop_detect_enable_q <= dat_i[CDMS_POS_OSC_STOP_DETECT_ENABLE];
        end
    end

    // module-stop register a
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mstpa_q <= CDMS_RST_MSTPA;
        end else if (ce_i && wr && adr_i == CDMS_ADR_MSTPA) begin
            mstpa_q <= lane_wr(mstpa_q, dat_i, sel_i);
        end
    end

    // power control: pin selects, operating mode, low-power mode choice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_pin_en_q <= 1'b0;
            sd_pin_en_q <= 1'b0;
            opm_q <= CDMS_RST_OPM;
            lpm_q <= CDMS_RST_LPM;
        end else if (ce_i && wr && adr_i == CDMS_ADR_PWR) begin
            if (sel_i[0]) begin
                bus_pin_en_q <= dat_i[CDMS_POS_BUSPIN];
                sd_pin_en_q <= dat_i[CDMS_POS_SDPIN];
                opm_q <= dat_i[CDMS_POS_OPM +: 2];
            end
            if (sel_i[1]) begin
                lpm_q <= dat_i[CDMS_POS_LPM +: 2];
            end
        end
    end

    // run / low-power sequencer; wake wins over a fresh entry request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= CDMS_ST_RUN;
        end else if (ce_i) begin
            case (st_q)
                CDMS_ST_RUN: begin
                    if (enter && !wake_s_q) begin
                        st_q <= CDMS_ST_LOW;
                    end
                end
                CDMS_ST_LOW: begin
                    if (wake_s_q) begin
                        st_q <= CDMS_ST_RUN;
                    end
                end
                default: begin
                    st_q <= CDMS_ST_RUN;
                end
            endcase
        end
    end

    // which clocks the current low-power mode stops
    always_comb begin
        gate = 7'h7F;
        if (st_q == CDMS_ST_LOW) begin
            case (lpm_q)
                CDMS_LPM_SLEEP: gate = 7'h3F;
                CDMS_LPM_ALLSTOP: gate = 7'h20;
                default: gate = 7'h00;
            endcase
        end
    end

    // shared free-running prescaler; a single counter keeps all ratios phase aligned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // one enable per derived clock, pulsing once per 2^code cycles (once per 64 for codes 6 and up)
    for (genvar g = 0; g < 7; g++) begin : g_div
        localparam int POS = (g == 6) ? CDMS_POS_FLASH : (g == 5) ? CDMS_POS_CORE :
                             (g == 4) ? CDMS_POS_BUS : g * 4;
        logic [CDMS_CNT_W-1:0] m;
        assign m = div_mask(div_q[POS +: 4]);
        assign raw_en[g] = (cnt_q & m) == m;
    end

    // registered clock enables, gated by low-power mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_en_o <= '0;
        end else if (ce_i) begin
            clk_en_o <= cdms_clk_en_t'(raw_en & gate);
        end
    end

    // per-module run enables: stop bit forces the module clock off
    for (genvar b = 0; b < 32; b++) begin : g_mod
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mod_run_o[b] <= 1'b0;
            end else if (ce_i) begin
                if (b == CDMS_POS_TPU0) begin
                    mod_run_o[b] <= raw_en[3] && gate[3] && !mstpa_q[b];
                end else if (b == CDMS_POS_ADC1) begin
                    mod_run_o[b] <= raw_en[0] && gate[0] && !mstpa_q[b];
                end else begin
                    mod_run_o[b] <= raw_en[2] && gate[2] && !mstpa_q[b];
                end
            end
        end
    end

    // pin clocks toggle on bus enables, so the pin runs at half the bus rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_pin_o <= 1'b1;
            sdram_pin_o <= 1'b1;
        end else if (ce_i) begin
            bus_pin_o <= !bus_pin_en_q ? 1'b1 : (clk_en_o.bus ? !bus_pin_o : bus_pin_o);
            sdram_pin_o <= !sd_pin_en_q ? 1'b1 : (clk_en_o.bus ? !sdram_pin_o : sdram_pin_o);
        end
    end

    // register outputs of configuration and state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_stop_detect_enable_o <= 1'b0;
            opmode_o <= CDMS_RST_OPM;
            lpm_o <= CDMS_RST_LPM;
            low_power_o <= 1'b0;
        end else if (ce_i) begin
            osc_stop_detect_enable_o <= osc_stop_detect_enable_q;
            opmode_o <= opm_q;
            lpm_o <= lpm_q;
            low_power_o <= (st_q == CDMS_ST_LOW);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_d = '0;
        case (adr_i)
            CDMS_ADR_DIV: rd_d = div_q;
            CDMS_ADR_OSTD: rd_d[CDMS_POS_OSC_STOP_DETECT_ENABLE] = osc_stop_detect_enable_q;
            CDMS_ADR_MSTPA: rd_d = mstpa_q;
            CDMS_ADR_PWR: begin
                rd_d[CDMS_POS_BUSPIN] = bus_pin_en_q;
                rd_d[CDMS_POS_SDPIN] = sd_pin_en_q;
                rd_d[CDMS_POS_OPM +: 2] = opm_q;
                rd_d[CDMS_POS_LPM +: 2] = lpm_q;
                rd_d[CDMS_POS_ENTER] = (st_q == CDMS_ST_LOW);
            end
            CDMS_ADR_STAT: begin
                rd_d[6:0] = clk_en_o;
                rd_d[8] = (st_q == CDMS_ST_LOW);
            end
            default: rd_d = '0;
        endcase
    end

    // read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (ce_i && acc && !we_i) begin
            dat_o <= rd_d;
        end
    end

    // checks
    AST_PB_DIV2: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_q == CDMS_ST_RUN && div_q[CDMS_POS_PB +: 4] == 4'h1 && raw_en[2]
        |-> !(cnt_q[0] == 1'b0))
        else $error("pb divide by two pulses on wrong phase");
    AST_BUS_DIV64: assert property (@(posedge clk_i) disable iff (rst_i)
        raw_en[4] && div_q[CDMS_POS_BUS +: 4] == 4'h6 |-> cnt_q == 6'h3F)
        else $error("bus divide by 64 enable off phase");
    AST_CORE_DIV1: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_q == CDMS_ST_RUN && div_q[CDMS_POS_CORE +: 4] == 4'h0 |=> clk_en_o.core)
        else $error("core divide by one not continuous");
    AST_PD_DIV4: assert property (@(posedge clk_i) disable iff (rst_i)
        raw_en[0] && div_q[CDMS_POS_PD +: 4] == 4'h2 |-> cnt_q[1:0] == 2'h3)
        else $error("pd divide by four off phase");
    AST_FLASH_DIV8: assert property (@(posedge clk_i) disable iff (rst_i)
        raw_en[6] && div_q[CDMS_POS_FLASH +: 4] == 4'h3 |-> cnt_q[2:0] == 3'h7)
        else $error("flash divide by eight off phase");
    AST_OSTD: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && adr_i == CDMS_ADR_OSTD && sel_i[0] && ce_i
        |=> osc_stop_detect_enable_q == $past(dat_i[CDMS_POS_OSC_STOP_DETECT_ENABLE]))
        else $error("oscillation stop enable not stored");
    AST_PIN_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !sd_pin_en_q |=> sdram_pin_o)
        else $error("sdram pin not held high when disabled");
    AST_CMTW_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mstpa_q[CDMS_POS_CMTW1] |=> !mod_run_o[CDMS_POS_CMTW1])
        else $error("stopped timer w unit still clocked");
    AST_ADC_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mstpa_q[CDMS_POS_ADC1] |=> !mod_run_o[CDMS_POS_ADC1])
        else $error("stopped adc unit still clocked");
    AST_DEEP_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_q == CDMS_ST_LOW && lpm_q == CDMS_LPM_DEEP |=> clk_en_o == '0)
        else $error("clocks run in deep standby");
endmodule

// File: test_clock_divider_and_module_stop.sv
// self-checking bench for the clock divider, pin clock and module-stop block
`timescale 1ns/100ps
module test_clock_divider_and_module_stop
    import cdms_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wake_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    cdms_clk_en_t clk_en_o;
    logic [31:0] mod_run_o;
    logic bus_pin_o;
    logic sdram_pin_o;
    logic osc_stop_detect_enable_o;
    logic [1:0] opmode_o;
    logic [1:0] lpm_o;
    logic low_power_o;
    int mismatches = 0;
    int n_compared = 0;
    int cnt [13];
    logic [31:0] q;

    // 200 MHz clock, half period 2.5 ns
    always #2.5 clk_i = ~clk_i;

    cdms_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wake_i(wake_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clk_en_o(clk_en_o),
        .mod_run_o(mod_run_o), .bus_pin_o(bus_pin_o), .sdram_pin_o(sdram_pin_o),
        .osc_stop_detect_enable_o(osc_stop_detect_enable_o), .opmode_o(opmode_o),
        .lpm_o(lpm_o), .low_power_o(low_power_o)
    );

    // compare and count; four-state so an unknown never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // classic single wishbone cycle; waits for ack without assuming latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 64);
        if (ack_o !== 1'b1) mismatches++;
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, 4'hF, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 4'hF, 32'h0, r);
        chk(r, exp);
    endtask

    // count enable pulses, selected module enables and pin toggles over a window
    task automatic sample(input int len);
        logic [6:0] e;
        logic bp;
        logic sp;
        foreach (cnt[i]) cnt[i] = 0;
        repeat (4) @(posedge clk_i);
        bp = bus_pin_o;
        sp = sdram_pin_o;
        repeat (len) begin
            @(posedge clk_i);
            e = clk_en_o;
            for (int i = 0; i < 7; i++) cnt[i] += int'(e[i]);
            cnt[7] += int'(mod_run_o[0]);
            cnt[8] += int'(mod_run_o[1]);
            cnt[9] += int'(mod_run_o[13]);
            cnt[10] += int'(mod_run_o[16]);
            cnt[11] += int'(bus_pin_o !== bp);
            cnt[12] += int'(sdram_pin_o !== sp);
            bp = bus_pin_o;
            sp = sdram_pin_o;
        end
    endtask

    task automatic t_reset;
        rd(CDMS_ADR_DIV, CDMS_RST_DIV);
        rd(CDMS_ADR_OSTD, {24'h0, CDMS_RST_OSTD});
        rd(CDMS_ADR_MSTPA, CDMS_RST_MSTPA);
        chk({30'h0, bus_pin_o, sdram_pin_o}, 32'h3);
        $display("test reset done");
    endtask

    // every field gets a different code, then a mixed set, then the first codes reversed
    task automatic t_div;
        logic [31:0] v [3];
        int pos [7];
        // only codes 0..6 are written; no pll here, so pd by one is allowed
        v = '{32'h6504_3210, 32'h3006_0122, 32'h0102_3456};
        pos = '{CDMS_POS_PD, CDMS_POS_PC, CDMS_POS_PB, CDMS_POS_PA, CDMS_POS_BUS,
                CDMS_POS_CORE, CDMS_POS_FLASH};
        for (int k = 0; k < 3; k++) begin
            wr(CDMS_ADR_DIV, v[k]);
            rd(CDMS_ADR_DIV, v[k]);
            sample(128);
            for (int f = 0; f < 7; f++)
                chk(32'(cnt[f]), 32'(128 >> v[k][pos[f] +: 4]));
            chk(32'(cnt[11]), 32'h0);
        end
        // only byte lane 0 written: peripheral D and C fields alone change
        wb(1'b1, CDMS_ADR_DIV, 4'h1, 32'hFFFF_FF55, q);
        rd(CDMS_ADR_DIV, 32'h0102_3455);
        $display("test dividers done");
    endtask

    // divider is now pd 5, pc 5, pb 4, pa 3, bus 2, core 1, flash 0
    task automatic t_stop;
        wr(CDMS_ADR_MSTPA, 32'hFFFE_DFFE);
        rd(CDMS_ADR_MSTPA, 32'hFFFE_DFFE);
        sample(128);
        chk(32'(cnt[7]), 32'h8);
        chk(32'(cnt[8]), 32'h0);
        chk(32'(cnt[9]), 32'h10);
        chk(32'(cnt[10]), 32'h4);
        wr(CDMS_ADR_MSTPA, 32'hFFFF_FFFD);
        sample(128);
        chk({cnt[7][7:0], cnt[8][7:0], cnt[9][7:0], cnt[10][7:0]}, 32'h0008_0000);
        $display("test module stop done");
    endtask

    task automatic t_osc;
        wr(CDMS_ADR_OSTD, 32'hFFFF_FFFF);
        rd(CDMS_ADR_OSTD, 32'h80);
        repeat (2) @(posedge clk_i);
        chk({31'h0, osc_stop_detect_enable_o}, 32'h1);
        wr(CDMS_ADR_OSTD, 32'h7F);
        rd(CDMS_ADR_OSTD, 32'h0);
        repeat (2) @(posedge clk_i);
        chk({31'h0, osc_stop_detect_enable_o}, 32'h0);
        // unmapped place: write dropped, read zero, divider untouched
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        rd(CDMS_ADR_DIV, 32'h0102_3455);
        $display("test oscillation stop done");
    endtask

    // pin clock is half the bus enable rate: one toggle per bus enable
    task automatic t_pins;
        wr(CDMS_ADR_PWR, 32'h3);
        sample(128);
        chk({cnt[11][15:0], cnt[12][15:0]}, 32'h0020_0020);
        wr(CDMS_ADR_PWR, 32'h2);
        sample(128);
        chk({cnt[11][15:0], cnt[12][15:0]}, 32'h0000_0020);
        chk({31'h0, bus_pin_o}, 32'h1);
        $display("test pins done");
    endtask

    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            wr(CDMS_ADR_PWR, (32'(i % 3) << CDMS_POS_OPM) | (32'(i) << CDMS_POS_LPM));
            repeat (2) @(posedge clk_i);
            chk({28'h0, opmode_o, lpm_o}, 32'((((i % 3) << 2) | i)));
        end
        // all-module stop keeps only the core enable running
        wr(CDMS_ADR_PWR, 32'h0000_1100);
        sample(64);
        chk({31'h0, low_power_o}, 32'h1);
        chk({cnt[3][15:0], cnt[5][15:0]}, 32'h0000_0020);
        wake_i <= 1'b1;
        for (int n = 0; n < 16 && low_power_o !== 1'b0; n++) @(posedge clk_i);
        chk({31'h0, low_power_o}, 32'h0);
        wake_i <= 1'b0;
        // let the synchronised wake fall first, or the entry is ignored
        repeat (3) @(posedge clk_i);
        wr(CDMS_ADR_PWR, 32'h0000_1300);
        sample(64);
        chk({31'h0, low_power_o}, 32'h1);
        chk(32'(cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4] + cnt[5] + cnt[6]), 32'h0);
        wake_i <= 1'b1;
        for (int n = 0; n < 16 && low_power_o !== 1'b0; n++) @(posedge clk_i);
        chk({31'h0, low_power_o}, 32'h0);
        wake_i <= 1'b0;
        $display("test power modes done");
    endtask

    // main sequence: reset for five cycles, then the scenarios in order
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_div();
        t_stop();
        t_osc();
        t_pins();
        t_modes();
        complete_run();
    end

    // hang guard, generous against the twelve hundred or so cycles the tests need
    initial begin
        #(20000 * 5);
        mismatches++;
        complete_run();
    end
endmodule
